// >>> dicd_defines.svh
// constants of the drive input command decoder: codes, defaults, settings
// assumes nothing; included by the package and the design modules
`ifndef DICD_DEFINES_SVH
`define DICD_DEFINES_SVH

`define DICD_MAX_DI 9
`define DICD_FCODE_W 7
`define DICD_SRC_W 3
`define DICD_WCM_W 2
`define DICD_ACC_W 2

// command source values
`define DICD_SRC_FACTORY 3'h0
`define DICD_SRC_PANEL 3'h1
`define DICD_SRC_DINS 3'h2
`define DICD_SRC_SER232 3'h4
`define DICD_SRC_SER485 3'h5
`define DICD_SRC_FIELDBUS 3'h6

// wire control method selecting enable / start edge / direction
`define DICD_WCM_3W_M2 2'h3

// access level needed to change input function codes
`define DICD_ACC_EXTENDED 2'h2

// input function codes
`define DICD_FC_LOCKED 7'h00
`define DICD_FC_ON_RAMP 7'h01
`define DICD_FC_FWD 7'h02
`define DICD_FC_COAST 7'h03
`define DICD_FC_RAPID 7'h04
`define DICD_FC_FAULT_ACK 7'h09
`define DICD_FC_JOG_FWD 7'h0A
`define DICD_FC_JOG_REV 7'h0B
`define DICD_FC_REVERSE 7'h0C
`define DICD_FC_MOP_UP 7'h0D
`define DICD_FC_MOP_UP2 7'h0E
`define DICD_FC_FIXF0 7'h0F
`define DICD_FC_DC_BRAKE 7'h19
`define DICD_FC_PID_EN 7'h1B
`define DICD_FC_EXT_FAULT 7'h1D
`define DICD_FC_ADDL_OFF 7'h21
`define DICD_FC_FREE 7'h63

`endif

// >>> dicd_pkg.sv
// types of the drive input command decoder
// assumes dicd_defines.svh is on the include path
`include "dicd_defines.svh"

package dicd_pkg;

  typedef logic [`DICD_FCODE_W-1:0] dicd_fcode_type;

  // motor command bundle handed to the drive control
  typedef struct packed {
    logic motor_on;
    logic reverse;
    logic ramp_stop;
    logic coast_stop;
    logic rapid_stop;
    logic fault_ack;
    logic jog_fwd;
    logic jog_rev;
    logic mop_up;
    logic [3:0] fix_freq;
    logic dc_brake;
    logic pid_enable;
    logic ext_fault;
    logic addl_sp_off;
    logic [`DICD_MAX_DI-1:0] free_lvl;
  } dicd_cmd_type;

  typedef enum logic [2:0] {
    DICD_ST_STOP = 3'h1,
    DICD_ST_FWD = 3'h2,
    DICD_ST_REV = 3'h4
  } dicd_state_type;

endpackage : dicd_pkg

// >>> dicd_edge.sv
// input synchroniser with rising and falling edge pulses
// assumes one clock; clk_en low freezes every stage
`timescale 1ns/1ps
`include "dicd_defines.svh"

module dicd_edge import dicd_pkg::*; #(
  parameter int WIDTH = 9
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // raw inputs
  input wire logic [WIDTH-1:0] din,
  // synchronised level and edges
  output logic [WIDTH-1:0] lvl,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] prev_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else if (clk_en) begin
      sync1_r <= din;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign lvl = sync2_r;
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  a_edge_one_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> ((rise & $past(rise)) == '0))
    else $error("edge pulse lasted more than one cycle");

endmodule : dicd_edge

// >>> dicd_top.sv
// drive input command decoder: command source, input functions, 3-wire m2
// assumes inputs synchronous-ish to sys_clk and a standstill flag from drive
`timescale 1ns/1ps
`include "dicd_defines.svh"

module dicd_top import dicd_pkg::*; #(
  parameter int NUM_DI = `DICD_MAX_DI,
  parameter bit HAS_FIELDBUS = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // digital inputs and drive status
  input wire logic [NUM_DI-1:0] digital_in,
  input wire logic motor_standstill,
  // settings
  input wire logic [`DICD_WCM_W-1:0] wire_control_method,
  input wire logic [`DICD_ACC_W-1:0] access_level,
  input wire logic factory_restore,
  input wire logic cmd_src_wr_en,
  input wire logic [`DICD_SRC_W-1:0] cmd_src_wr_data,
  input wire logic fcode_wr_en,
  input wire logic [3:0] fcode_wr_idx,
  input wire dicd_fcode_type fcode_wr_data,
  // results
  output dicd_cmd_type cmd_r,
  output logic [`DICD_SRC_W-1:0] command_source_select_r,
  output logic wr_refused_r
);

  localparam logic [`DICD_SRC_W-1:0] DEF_SRC =
    HAS_FIELDBUS ? `DICD_SRC_FIELDBUS : `DICD_SRC_DINS;

  logic [NUM_DI-1:0][`DICD_FCODE_W-1:0] fcode_r;
  dicd_state_type state_r;
  dicd_state_type state_nxt;
  logic [NUM_DI-1:0] lvl;
  logic [NUM_DI-1:0] rise;
  logic [NUM_DI-1:0] fall;

  // mask of inputs carrying a given function code
  function automatic logic [NUM_DI-1:0] dicd_match(
    input logic [NUM_DI-1:0][`DICD_FCODE_W-1:0] codes,
    input dicd_fcode_type code
  );
    logic [NUM_DI-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_DI; i++) begin
      m[i] = (codes[i] == code);
    end
    return m;
  endfunction : dicd_match

  // factory assignment of each input
  function automatic dicd_fcode_type dicd_factory(input int idx);
    dicd_fcode_type c;
    case (idx)
      0: c = `DICD_FC_ON_RAMP;
      1: c = `DICD_FC_REVERSE;
      2: c = `DICD_FC_FAULT_ACK;
      3, 4, 5, 6: c = `DICD_FC_FIXF0 + dicd_fcode_type'(idx - 3);
      default: c = `DICD_FC_LOCKED;
    endcase
    return c;
  endfunction : dicd_factory

  dicd_edge #(
    .WIDTH(NUM_DI)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(digital_in),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  // role decode from function codes, so any input can take any role
  logic [NUM_DI-1:0] m_en;
  logic [NUM_DI-1:0] m_start;
  logic [NUM_DI-1:0] m_dir;
  logic en_lvl;
  logic start_lvl;
  logic start_rise;
  logic dir_lvl;
  logic dir_rise;
  logic dir_fall;
  logic dins_sel;
  logic m3;
  logic wr_in_range;
  logic wr_ok;

  assign m_en = dicd_match(fcode_r, `DICD_FC_ON_RAMP);
  assign m_start = dicd_match(fcode_r, `DICD_FC_FWD);
  assign m_dir = dicd_match(fcode_r, `DICD_FC_REVERSE);
  assign en_lvl = |(lvl & m_en);
  assign start_lvl = |(lvl & m_start);
  assign start_rise = |(rise & m_start);
  assign dir_lvl = |(lvl & m_dir);
  assign dir_rise = |(rise & m_dir);
  assign dir_fall = |(fall & m_dir);
  assign dins_sel = (command_source_select_r == `DICD_SRC_DINS);
  assign m3 = (wire_control_method == `DICD_WCM_3W_M2);
  assign wr_in_range = (32'(fcode_wr_idx) < NUM_DI);

  // a free-interconnect input stays free until a factory restore
  always_comb begin
    wr_ok = 1'b0;
    if (wr_in_range && access_level == `DICD_ACC_EXTENDED) begin
      wr_ok = (fcode_r[fcode_wr_idx] != `DICD_FC_FREE);
    end
  end

  // function code store; restore has priority over a write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DI; i++) begin
        fcode_r[i] <= dicd_factory(i);
      end
    end else if (clk_en) begin
      if (factory_restore) begin
        for (int i = 0; i < NUM_DI; i++) begin
          fcode_r[i] <= dicd_factory(i);
        end
      end else if (fcode_wr_en && wr_ok) begin
        fcode_r[fcode_wr_idx] <= fcode_wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_refused_r <= 1'b0;
    end else if (clk_en) begin
      wr_refused_r <= fcode_wr_en && !factory_restore && !wr_ok;
    end
  end

  // command source setting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_source_select_r <= DEF_SRC;
    end else if (clk_en) begin
      if (factory_restore) begin
        command_source_select_r <= DEF_SRC;
      end else if (cmd_src_wr_en) begin
        command_source_select_r <= cmd_src_wr_data;
      end
    end
  end

  // run state; other methods follow input levels, method 2 uses edges
  always_comb begin
    state_nxt = state_r;
    if (!dins_sel) begin
      state_nxt = DICD_ST_STOP;
    end else if (m3) begin
      if (!en_lvl) begin
        if (!motor_standstill) begin
          state_nxt = DICD_ST_STOP;
        end
      end else if (motor_standstill) begin
        if (start_rise) begin
          state_nxt = dir_lvl ? DICD_ST_REV : DICD_ST_FWD;
        end
      end else if (!start_lvl && state_r != DICD_ST_STOP) begin
        if (dir_fall) begin
          state_nxt = DICD_ST_FWD;
        end else if (dir_rise) begin
          state_nxt = DICD_ST_REV;
        end
      end
    end else if (en_lvl || start_lvl) begin
      state_nxt = dir_lvl ? DICD_ST_REV : DICD_ST_FWD;
    end else begin
      state_nxt = DICD_ST_STOP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DICD_ST_STOP;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // motor command outputs; all but free_lvl idle unless the digital inputs command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= '0;
    end else if (clk_en) begin
      cmd_r.motor_on <= (state_nxt != DICD_ST_STOP);
      cmd_r.reverse <= (state_nxt == DICD_ST_REV);
      cmd_r.ramp_stop <= dins_sel && (state_nxt == DICD_ST_STOP);
      cmd_r.coast_stop <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_COAST));
      cmd_r.rapid_stop <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_RAPID));
      cmd_r.fault_ack <= dins_sel &&
        |(rise & dicd_match(fcode_r, `DICD_FC_FAULT_ACK));
      cmd_r.jog_fwd <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_JOG_FWD));
      cmd_r.jog_rev <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_JOG_REV));
      // both printed codes raise the frequency until 14 is confirmed
      cmd_r.mop_up <= dins_sel &&
        |(lvl & (dicd_match(fcode_r, `DICD_FC_MOP_UP) |
                 dicd_match(fcode_r, `DICD_FC_MOP_UP2)));
      for (int b = 0; b < 4; b++) begin
        cmd_r.fix_freq[b] <= dins_sel && |(lvl & dicd_match(fcode_r,
          `DICD_FC_FIXF0 + dicd_fcode_type'(b)));
      end
      cmd_r.dc_brake <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_DC_BRAKE));
      cmd_r.pid_enable <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_PID_EN));
      cmd_r.ext_fault <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_EXT_FAULT));
      cmd_r.addl_sp_off <= dins_sel &&
        |(lvl & dicd_match(fcode_r, `DICD_FC_ADDL_OFF));
      // free inputs only pass their level; routing is up to the user
      cmd_r.free_lvl <= `DICD_MAX_DI'(lvl &
        dicd_match(fcode_r, `DICD_FC_FREE));
    end
  end

  a_enable_low_stop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && !en_lvl && !motor_standstill
    |=> cmd_r.ramp_stop && !cmd_r.motor_on)
    else $error("enable low while rotating did not ramp stop");

  a_start_forward: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && motor_standstill && start_rise &&
    !dir_lvl |=> cmd_r.motor_on && !cmd_r.reverse)
    else $error("start edge did not run forward");

  a_start_inverted: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && motor_standstill && start_rise &&
    dir_lvl |=> cmd_r.motor_on && cmd_r.reverse)
    else $error("start edge did not run inverted");

  a_reverse_normal: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && !motor_standstill && !start_lvl &&
    state_r != DICD_ST_STOP && dir_fall
    |=> cmd_r.motor_on && !cmd_r.reverse)
    else $error("direction fall did not reverse to setpoint");

  a_reverse_invert: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && !motor_standstill && !start_lvl &&
    state_r != DICD_ST_STOP && dir_rise
    |=> cmd_r.motor_on && cmd_r.reverse)
    else $error("direction rise did not reverse to inverted");

  a_start_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && !motor_standstill &&
    !dir_rise && !dir_fall |=> $stable(state_r))
    else $error("start edge acted while rotating");

  a_dir_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && dins_sel && m3 && en_lvl && motor_standstill && !start_rise
    |=> $stable(state_r))
    else $error("direction edge acted at standstill");

  a_source_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !dins_sel |=> !cmd_r.motor_on && !cmd_r.ramp_stop)
    else $error("commands issued with another source selected");

  a_free_locked: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && fcode_wr_en && !factory_restore && wr_in_range &&
    fcode_r[fcode_wr_idx] == `DICD_FC_FREE
    |=> wr_refused_r && $stable(fcode_r))
    else $error("free interconnect code was overwritten");

  a_access_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && fcode_wr_en && !factory_restore &&
    access_level != `DICD_ACC_EXTENDED |=> wr_refused_r && $stable(fcode_r))
    else $error("code changed without extended access");

  a_factory_map: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && factory_restore |=> fcode_r[0] == `DICD_FC_ON_RAMP &&
    fcode_r[1] == `DICD_FC_REVERSE && fcode_r[2] == `DICD_FC_FAULT_ACK &&
    command_source_select_r == DEF_SRC)
    else $error("factory restore did not load defaults");

  c_start_run: cover property (@(posedge sys_clk) disable iff (!rst_n)
    m3 && dins_sel && start_rise && motor_standstill ##1 cmd_r.motor_on);
  c_reverse: cover property (@(posedge sys_clk) disable iff (!rst_n)
    m3 && cmd_r.motor_on && !cmd_r.reverse ##[1:20] cmd_r.reverse);
  c_refused: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_refused_r);

endmodule : dicd_top

// >>> dicd_far_side.sv
// far side model: switches on the digital inputs, drive standstill flag
// assumes the bench calls its tasks; levels move only at falling edges
`timescale 1ns/1ps

module dicd_far_side (
  // clock
  input wire logic sys_clk,
  // switch levels and drive status
  output logic [8:0] digital_in,
  output logic motor_standstill
);
  initial begin
    digital_in = 9'h000;
    motor_standstill = 1'b1;
  end

  // switches hold their level; no bounce is modelled, so any filtering
  // of contact chatter in the decoder goes unexercised
  task set_in(input int i, input logic v);
    @(negedge sys_clk);
    digital_in[i] = v;
  endtask : set_in

  // the drive control, not the decoder, knows whether the shaft turns
  task set_still(input logic v);
    @(negedge sys_clk);
    motor_standstill = v;
  endtask : set_still
endmodule : dicd_far_side

// >>> drive_input_command_decoder_bench.sv
// self-checking bench of the drive input command decoder
// assumes dicd_top with nine inputs and a fieldbus; far side in dicd_far_side
`timescale 1ns/1ps
`include "dicd_defines.svh"

module drive_input_command_decoder_bench import dicd_pkg::*; ;
  logic sys_clk, rst_n, clk_en, factory_restore, cmd_src_wr_en, fcode_wr_en;
  logic motor_standstill, refused;
  logic [8:0] digital_in;
  logic [1:0] wcm, acc;
  logic [2:0] src_d, src_r;
  logic [3:0] idx;
  dicd_fcode_type fdata;
  dicd_cmd_type cmd_r;
  int errors, n_compared, cycles, n_ack, ack0;
  int codes[20] = '{0, 1, 2, 3, 4, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18,
                    25, 27, 29, 33, 99};
  int srcs[6] = '{0, 1, 4, 5, 6, 2};

  dicd_far_side u_far (.sys_clk(sys_clk), .digital_in(digital_in),
    .motor_standstill(motor_standstill));

  dicd_top #(.NUM_DI(9), .HAS_FIELDBUS(1'b1)) DUT (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .digital_in(digital_in),
    .motor_standstill(motor_standstill), .wire_control_method(wcm),
    .access_level(acc), .factory_restore(factory_restore),
    .cmd_src_wr_en(cmd_src_wr_en), .cmd_src_wr_data(src_d),
    .fcode_wr_en(fcode_wr_en), .fcode_wr_idx(idx), .fcode_wr_data(fdata),
    .cmd_r(cmd_r), .command_source_select_r(src_r), .wr_refused_r(refused));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // the acknowledge is a one-cycle pulse, so count it at every falling edge
  always @(negedge sys_clk) begin
    if (cmd_r.fault_ack === 1'b1) n_ack++;
  end

  // sequence needs about 370 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task test_done;
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task check(input string name, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // two sync flops plus the output register, with two cycles to spare
  task settle;
    repeat (5) @(negedge sys_clk);
  endtask : settle

  task wr_code(input logic [3:0] i, input dicd_fcode_type c, input logic r);
    @(negedge sys_clk);
    fcode_wr_en = 1'b1;
    idx = i;
    fdata = c;
    @(negedge sys_clk);
    fcode_wr_en = 1'b0;
    check("wr_refused_r", refused, r);
  endtask : wr_code

  task wr_src(input logic [2:0] v);
    @(negedge sys_clk);
    cmd_src_wr_en = 1'b1;
    src_d = v;
    @(negedge sys_clk);
    cmd_src_wr_en = 1'b0;
    check("command_source_select_r", src_r, v);
  endtask : wr_src

  function automatic dicd_cmd_type exp_of(input int code);
    dicd_cmd_type e;
    e = '0;
    e.ramp_stop = 1'b1;
    case (code)
      1, 2: begin
        e.motor_on = 1'b1;
        e.ramp_stop = 1'b0;
      end
      3: e.coast_stop = 1'b1;
      4: e.rapid_stop = 1'b1;
      10: e.jog_fwd = 1'b1;
      11: e.jog_rev = 1'b1;
      // reverse only shows while the motor is commanded on
      13, 14: e.mop_up = 1'b1;
      15, 16, 17, 18: e.fix_freq[code-15] = 1'b1;
      25: e.dc_brake = 1'b1;
      27: e.pid_enable = 1'b1;
      29: e.ext_fault = 1'b1;
      33: e.addl_sp_off = 1'b1;
      99: e.free_lvl[7] = 1'b1;
      default: ;
    endcase
    return e;
  endfunction : exp_of

  task run_chk(input logic on, input logic rev);
    settle();
    check("motor_on", cmd_r.motor_on, on);
    check("reverse", cmd_r.reverse, rev);
  endtask : run_chk

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    factory_restore = 1'b0;
    cmd_src_wr_en = 1'b0;
    fcode_wr_en = 1'b0;
    wcm = 2'h0;
    acc = 2'h1;
    src_d = 3'h0;
    idx = 4'h0;
    fdata = 7'h00;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    check("command_source_select_r", src_r, 3'h6);
    u_far.set_in(0, 1'b1);
    foreach (srcs[k]) begin
      wr_src(srcs[k][2:0]);
      settle();
      check("motor_on", cmd_r.motor_on, srcs[k] == 2);
    end
    u_far.set_in(1, 1'b1);
    settle();
    check("reverse", cmd_r.reverse, 1'b1);
    u_far.set_in(0, 1'b0);
    u_far.set_in(1, 1'b0);
    ack0 = n_ack;
    u_far.set_in(2, 1'b1);
    settle();
    check("fault_ack pulses", n_ack - ack0, 1);
    u_far.set_in(2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      u_far.set_in(3 + i, 1'b1);
      settle();
      check("fix_freq", cmd_r.fix_freq, 4'h1 << i);
      u_far.set_in(3 + i, 1'b0);
    end
    wr_code(4'h8, 7'h03, 1'b1);
    u_far.set_in(8, 1'b1);
    settle();
    check("cmd_r", cmd_r, exp_of(0));
    u_far.set_in(8, 1'b0);
    acc = 2'h2;
    wr_code(4'h9, 7'h03, 1'b1);
    foreach (codes[k]) begin
      wr_code(4'h7, codes[k][6:0], 1'b0);
      ack0 = n_ack;
      u_far.set_in(7, 1'b1);
      settle();
      check("cmd_r", cmd_r, exp_of(codes[k]));
      check("fault_ack pulses", n_ack - ack0, codes[k] == 9);
      u_far.set_in(7, 1'b0);
    end
    wr_code(4'h7, 7'h00, 1'b1);
    @(negedge sys_clk);
    factory_restore = 1'b1;
    @(negedge sys_clk);
    factory_restore = 1'b0;
    check("command_source_select_r", src_r, 3'h6);
    wr_src(3'h2);
    u_far.set_in(7, 1'b1);
    settle();
    check("cmd_r", cmd_r, exp_of(0));
    u_far.set_in(7, 1'b0);
    // start and direction moved off their printed inputs; enable stays on input 0
    wcm = 2'h3;
    wr_code(4'h1, 7'h02, 1'b0);
    wr_code(4'h2, 7'h0C, 1'b0);
    u_far.set_in(0, 1'b1);
    u_far.set_in(1, 1'b1);
    run_chk(1'b1, 1'b0);
    u_far.set_still(1'b0);
    u_far.set_in(1, 1'b0);
    u_far.set_in(2, 1'b1);
    run_chk(1'b1, 1'b1);
    u_far.set_in(2, 1'b0);
    run_chk(1'b1, 1'b0);
    u_far.set_in(1, 1'b1);
    u_far.set_in(2, 1'b1);
    run_chk(1'b1, 1'b0);
    u_far.set_in(1, 1'b0);
    u_far.set_in(0, 1'b0);
    run_chk(1'b0, 1'b0);
    check("ramp_stop", cmd_r.ramp_stop, 1'b1);
    u_far.set_still(1'b1);
    u_far.set_in(0, 1'b1);
    u_far.set_in(2, 1'b0);
    u_far.set_in(2, 1'b1);
    run_chk(1'b0, 1'b0);
    u_far.set_in(1, 1'b1);
    run_chk(1'b1, 1'b1);
    u_far.set_in(0, 1'b0);
    run_chk(1'b1, 1'b1);
    // clk_en low must hold the run state although enable is low
    clk_en = 1'b0;
    u_far.set_still(1'b0);
    settle();
    check("motor_on", cmd_r.motor_on, 1'b1);
    clk_en = 1'b1;
    run_chk(1'b0, 1'b0);
    check("ramp_stop", cmd_r.ramp_stop, 1'b1);
    test_done();
  end
endmodule : drive_input_command_decoder_bench
